// ===== cpw_pkg.sv
// Constants, types and decoding shared by the charge port control logic
// Summary of operation
// - Wake hold only for pin changes 111 to 011 and 010 to 011
// - Change 110 to 011 is an ordinary mode change, no wake hold
// - Transient 111 seen while leaving 110 enters 111 with output discharge
// - Low-speed attach is detected only in standard or charging-port modes
// - D- level alone is watched; full-speed devices stay unseen
// - With low-speed device seen, command 011 is ignored; switches stay on
// - Momentary D- low while holding starts the wake countdown
// - Countdown expiry with 011 still set moves at once to auto mode
// - Pins 0011 enable the supply wake function
// - Supply wake with load charging holds STATUS low
// - Load under 45 mA over 15 s sets 55 mA limit, releases STATUS
// - Hitting the 55 mA limit drives STATUS low again
// - After STATUS reasserts the output discharges about 330 ms
// - After that discharge the switch returns with the high limit
// - Non-charging standard port uses the low current limit
// - Variant two to charging port by limit pin needs no discharge
// - Charging mode and pins 0111 auto mode assert STATUS after load above low+75 mA 200 ms
// - Charging-port mode asserts STATUS on a primary detection
// - STATUS released after load below low+25 mA for 3 s
// - Data switches stay open during any output discharge
// - Pins 011 with limit select 1 give auto mode with load detect, without supply wake
package cpw_pkg;

   // ===================================================================
   // Timing
   localparam int CLK_PERIOD_NS  = 5;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYC_DEF   =
      (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TMR_W          = 16;
   localparam logic [TMR_W-1:0] WAKE_MS     = 16'd64;
   localparam logic [TMR_W-1:0] LOAD_ON_MS  = 16'd200;
   localparam logic [TMR_W-1:0] LOAD_OFF_MS = 16'd3000;
   localparam logic [TMR_W-1:0] PW_IDLE_MS  = 16'd15001;
   localparam logic [TMR_W-1:0] PW_DISCH_MS = 16'd330;
   localparam logic [TMR_W-1:0] MODE_DISCH_MS = 16'd10;

   // ===================================================================
   // Pin commands, ordered mode_pin_a, mode_pin_b, mode_pin_c
   localparam logic [2:0] CMD_OFF    = 3'h0;
   localparam logic [2:0] CMD_PWAUTO = 3'h1;
   localparam logic [2:0] CMD_SDP1B  = 3'h2;
   localparam logic [2:0] CMD_AUTO   = 3'h3;
   localparam logic [2:0] CMD_SDP1A  = 3'h6;
   localparam logic [2:0] CMD_CDP    = 3'h7;

   // ===================================================================
   // Register map
   localparam logic [7:0]  ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_STATE  = 8'h04;
   localparam int          CTRL_WAKE_BIT = 0;
   localparam int          CTRL_LOAD_BIT = 1;
   localparam logic [1:0]  CTRL_RESET  = 2'h3;
   localparam int          ST_STATUS_BIT = 0;
   localparam int          ST_PWLOW_BIT  = 1;
   localparam int          ST_PPM_BIT    = 2;
   localparam int          ST_LS_BIT     = 3;
   localparam int          ST_HOLD_BIT   = 4;
   localparam int          ST_MODE_LSB   = 8;

   typedef enum logic [2:0] {
      MODE_OFF, MODE_STANDARD_PORT_VARIANT_ONE, MODE_STANDARD_PORT_VARIANT_TWO, MODE_CDP,
      MODE_AUTO, MODE_FORCED, MODE_DISCH
   } cpw_mode_t;

   // ===================================================================
   // Pin decode to operating mode
   function automatic cpw_mode_t cpw_decode(input logic [2:0] cmd,
                                            input logic       lim);
      cpw_mode_t m;
      m = MODE_FORCED;
      unique case (cmd)
         CMD_OFF:    m = MODE_OFF;
         CMD_SDP1A,
         CMD_SDP1B:  m = MODE_STANDARD_PORT_VARIANT_ONE;
         CMD_CDP:    m = lim ? MODE_CDP : MODE_STANDARD_PORT_VARIANT_TWO;
         CMD_AUTO,
         CMD_PWAUTO: m = MODE_AUTO;
         default:    m = MODE_FORCED;
      endcase
      return m;
   endfunction

   function automatic logic cpw_is_data_mode(input cpw_mode_t m);
      return (m == MODE_STANDARD_PORT_VARIANT_ONE) || (m == MODE_STANDARD_PORT_VARIANT_TWO) || (m == MODE_CDP);
   endfunction

endpackage

// ===== cpw_timer_if.sv
// Control and result signals of one tick-based interval timer
`timescale 1ns/1ps
`default_nettype none
interface cpw_timer_if #(parameter int W = 16);
   logic         run;
   logic         tick;
   logic [W-1:0] limit;
   logic         done;
   modport ctrl (output run, output tick, output limit, input done);
   modport tmr  (input run, input tick, input limit, output done);
endinterface
`default_nettype wire

// ===== cpw_tick_timer.sv
// Interval timer counting tick pulses while its run level is held
`timescale 1ns/1ps
`default_nettype none
module cpw_tick_timer
   import cpw_pkg::*;
#(
   parameter int W = TMR_W
)(
   input  wire logic mclk,
   input  wire logic rst_n,
   cpw_timer_if.tmr  t
);
   logic [W-1:0] cnt_q;

   // Restarts whenever run drops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (!t.run) begin
         cnt_q <= '0;
      end else if (t.tick && (cnt_q != t.limit)) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign t.done = t.run && (cnt_q == t.limit);
endmodule
`default_nettype wire

// ===== cpw_charge_port_ctrl.sv
// Charge port mode, wake hold and load detect control with APB registers
`timescale 1ns/1ps
`default_nettype none
module cpw_charge_port_ctrl
   import cpw_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYC_DEF
)(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        modePinA,
   input  wire logic        modePinB,
   input  wire logic        modePinC,
   input  wire logic        limitSelectPin,
   input  wire logic        dMinusHigh,
   input  wire logic        loadAboveOn,
   input  wire logic        loadBelowOff,
   input  wire logic        loadBelow45,
   input  wire logic        limit55Hit,
   input  wire logic        primaryDetect,
   output logic             statusO,
   output logic             statusOe_n,
   output logic             dataSwitchOn,
   output logic             dischargeOn,
   output logic             powerSwitchOn,
   output logic             highLimitOn,
   output logic             supplyWakeLimitOn
);
   localparam int TW = $clog2(TICK_CYC + 1);

   logic [2:0]    cmd;
   cpw_mode_t     target;
   cpw_mode_t     mode_q;
   cpw_mode_t     retMode_q;
   logic [2:0]    lastCmd_q;
   logic [1:0]    ctrl_q;
   logic [TW-1:0] tickCnt_q;
   logic          tick;
   logic          lsSeen_q;
   logic          dMinusPrev_q;
   logic          wakeRun_q;
   logic          dischPw_q;
   logic          pwLow_q;
   logic          ppm_q;
   logic          hold;
   logic          pwMode;
   logic          pwActive;
   logic          loadDet;
   logic          statusLow;
   logic          noDisch;
   logic          apbAccess;
   logic          addrOk;
   logic [31:0]   prdata_q;

   cpw_timer_if #(.W(TMR_W)) wakeIf ();
   cpw_timer_if #(.W(TMR_W)) qualIf ();
   cpw_timer_if #(.W(TMR_W)) dischIf ();

   cpw_tick_timer #(.W(TMR_W)) uWake (.mclk(mclk), .rst_n(rst_n),
                                      .t(wakeIf));
   cpw_tick_timer #(.W(TMR_W)) uQual (.mclk(mclk), .rst_n(rst_n),
                                      .t(qualIf));
   cpw_tick_timer #(.W(TMR_W)) uDisch (.mclk(mclk), .rst_n(rst_n),
                                       .t(dischIf));

   // ===================================================================
   // Millisecond tick
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tickCnt_q <= '0;
      end else if (tickCnt_q == TW'(TICK_CYC - 1)) begin
         tickCnt_q <= '0;
      end else begin
         tickCnt_q <= tickCnt_q + 1'b1;
      end
   end
   assign tick = (tickCnt_q == TW'(TICK_CYC - 1));

   // ===================================================================
   // Command decode and wake hold
   assign cmd    = {modePinA, modePinB, modePinC};
   assign target = cpw_decode(cmd, limitSelectPin);
   assign pwMode = (cmd == CMD_PWAUTO) && limitSelectPin;
   assign pwActive = pwMode && (mode_q == MODE_AUTO);
   assign loadDet  = ctrl_q[CTRL_LOAD_BIT] &&
                     ((mode_q == MODE_CDP) ||
                      ((mode_q == MODE_AUTO) && (cmd == CMD_AUTO) &&
                       limitSelectPin));

   assign hold = ctrl_q[CTRL_WAKE_BIT] && lsSeen_q &&
                 cpw_is_data_mode(mode_q) && (cmd == CMD_AUTO) &&
                 ((lastCmd_q == CMD_CDP) ||
                  (lastCmd_q == CMD_SDP1B));

   assign noDisch = ((mode_q == MODE_STANDARD_PORT_VARIANT_TWO) && (target == MODE_CDP)) ||
                    ((mode_q == MODE_CDP) && (target == MODE_STANDARD_PORT_VARIANT_TWO)) ||
                    (mode_q == MODE_OFF) || (target == MODE_OFF);

   // Low-speed idle device seen on D- while data path is active
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lsSeen_q <= 1'b0;
      end else if (!cpw_is_data_mode(mode_q)) begin
         lsSeen_q <= 1'b0;
      end else if (dMinusHigh) begin
         lsSeen_q <= 1'b1;
      end
   end

   // Last command honoured, frozen while the hold is in force
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lastCmd_q <= CMD_OFF;
      end else if (!hold && (mode_q != MODE_DISCH)) begin
         lastCmd_q <= cmd;
      end
   end

   // Wake countdown armed by a D- low pulse
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dMinusPrev_q <= 1'b0;
         wakeRun_q    <= 1'b0;
      end else begin
         dMinusPrev_q <= dMinusHigh;
         if (!hold) begin
            wakeRun_q <= 1'b0;
         end else if (dMinusPrev_q && !dMinusHigh) begin
            wakeRun_q <= 1'b1;
         end
      end
   end

   assign wakeIf.run   = wakeRun_q && hold;
   assign wakeIf.tick  = tick;
   assign wakeIf.limit = WAKE_MS;

   // ===================================================================
   // Mode sequencing
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q    <= MODE_OFF;
         retMode_q <= MODE_OFF;
         dischPw_q <= 1'b0;
      end else if (mode_q == MODE_DISCH) begin
         if (dischIf.done) begin
            mode_q <= retMode_q;
         end
      end else if (hold) begin
         if (wakeIf.done) begin
            mode_q <= MODE_AUTO;
         end
      end else if (pwActive && pwLow_q && limit55Hit) begin
         mode_q    <= MODE_DISCH;
         retMode_q <= MODE_AUTO;
         dischPw_q <= 1'b1;
      end else if (target != mode_q) begin
         if (noDisch) begin
            mode_q <= target;
         end else begin
            mode_q    <= MODE_DISCH;
            retMode_q <= target;
            dischPw_q <= 1'b0;
         end
      end
   end

   assign dischIf.run   = (mode_q == MODE_DISCH);
   assign dischIf.tick  = tick;
   assign dischIf.limit = dischPw_q ? PW_DISCH_MS : MODE_DISCH_MS;

   // ===================================================================
   // Supply wake and load detect
   always_comb begin
      qualIf.run   = 1'b0;
      qualIf.limit = LOAD_ON_MS;
      if (pwActive && !pwLow_q) begin
         qualIf.run   = loadBelow45;
         qualIf.limit = PW_IDLE_MS;
      end else if (loadDet && !ppm_q) begin
         qualIf.run   = loadAboveOn;
         qualIf.limit = LOAD_ON_MS;
      end else if (loadDet) begin
         qualIf.run   = loadBelowOff;
         qualIf.limit = LOAD_OFF_MS;
      end
   end
   assign qualIf.tick = tick;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pwLow_q <= 1'b0;
      end else if (!pwActive) begin
         pwLow_q <= 1'b0;
      end else if (!pwLow_q && qualIf.done) begin
         pwLow_q <= 1'b1;
      end else if (pwLow_q && limit55Hit) begin
         pwLow_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ppm_q <= 1'b0;
      end else if (!loadDet) begin
         ppm_q <= 1'b0;
      end else if (!ppm_q) begin
         if (qualIf.done ||
             (primaryDetect && (mode_q == MODE_CDP))) begin
            ppm_q <= 1'b1;
         end
      end else if (qualIf.done) begin
         ppm_q <= 1'b0;
      end
   end

   // ===================================================================
   // Pin outputs
   assign statusLow  = pwMode ? !pwLow_q : ppm_q;
   assign statusO    = 1'b0;
   assign statusOe_n = !statusLow;
   assign dataSwitchOn  = cpw_is_data_mode(mode_q);
   assign dischargeOn   = (mode_q == MODE_DISCH);
   assign powerSwitchOn = (mode_q != MODE_OFF) && (mode_q != MODE_DISCH);
   assign highLimitOn   = (mode_q == MODE_CDP) || (mode_q == MODE_AUTO) ||
                          (mode_q == MODE_FORCED) ||
                          ((mode_q == MODE_STANDARD_PORT_VARIANT_ONE) && limitSelectPin);
   assign supplyWakeLimitOn = pwActive && pwLow_q;

   // ===================================================================
   // APB slave, zero wait states
   assign apbAccess = psel && penable;
   assign addrOk    = (paddr == ADDR_CTRL) || (paddr == ADDR_STATE);
   assign pready    = 1'b1;
   assign pslverr   = apbAccess && !addrOk;
   assign prdata    = prdata_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RESET;
      end else if (apbAccess && pwrite && (paddr == ADDR_CTRL)) begin
         ctrl_q <= pwdata[1:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_q <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata_q <= 32'h0000_0000;
         if (paddr == ADDR_CTRL) begin
            prdata_q[1:0] <= ctrl_q;
         end else if (paddr == ADDR_STATE) begin
            prdata_q[ST_STATUS_BIT] <= statusLow;
            prdata_q[ST_PWLOW_BIT]  <= pwLow_q;
            prdata_q[ST_PPM_BIT]    <= ppm_q;
            prdata_q[ST_LS_BIT]     <= lsSeen_q;
            prdata_q[ST_HOLD_BIT]   <= hold;
            prdata_q[ST_MODE_LSB +: 3] <= mode_q;
         end
      end
   end

   // ===================================================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   disch_open_a: assert property (dischargeOn |-> !dataSwitchOn)
      else $error("Data switches closed during discharge");
   hold_keep_a: assert property (hold && !wakeIf.done |=>
      $stable(mode_q) && dataSwitchOn)
      else $error("Mode moved while wake hold active");
   wake_expire_a: assert property (hold && wakeIf.done |=>
      mode_q == MODE_AUTO && !dataSwitchOn)
      else $error("Wake expiry did not enter auto mode");
   no_hold_110_a: assert property (
      (lastCmd_q == CMD_SDP1A) |-> !hold)
      else $error("Hold applied after 110 command");
   standard_port_variant_two_cdp_a: assert property (
      mode_q == MODE_STANDARD_PORT_VARIANT_TWO && target == MODE_CDP && !hold
      |=> mode_q == MODE_CDP)
      else $error("Variant two to charging port not direct");
   pw_release_a: assert property (
      pwActive && !pwLow_q && qualIf.done
      |=> (pwLow_q && !statusLow) || !pwActive)
      else $error("Supply wake idle did not release status");
   pw_reassert_a: assert property (
      pwActive && pwLow_q && limit55Hit |=> statusLow && dischargeOn)
      else $error("Low limit hit without reassert and discharge");
   disch_exit_a: assert property (
      dischargeOn && dischIf.done |=> mode_q == $past(retMode_q))
      else $error("Discharge did not return to target mode");
   primary_a: assert property (
      loadDet && mode_q == MODE_CDP && primaryDetect |=> ppm_q)
      else $error("Primary detection did not assert status");
   standard_port_variant_two_low_a: assert property (mode_q == MODE_STANDARD_PORT_VARIANT_TWO |-> !highLimitOn)
      else $error("Non-charging port not on low limit");

   ls_clear_a: assert property (
      !cpw_is_data_mode(mode_q) |=> !lsSeen_q)
      else $error("Low-speed flag kept outside data modes");
   ls_seen_a: assert property (
      cpw_is_data_mode(mode_q) && dMinusHigh |=> lsSeen_q)
      else $error("Idle D- high not flagged");
   wake_start_a: assert property (
      hold && dMinusPrev_q && !dMinusHigh |=> wakeRun_q)
      else $error("D- fall did not start wake countdown");
   pw_hold_a: assert property (
      pwActive && !pwLow_q |-> !statusOe_n)
      else $error("Supply wake charging without status low");
   pw_idle_a: assert property (
      pwActive && !pwLow_q && !loadBelow45 |=> !qualIf.done)
      else $error("Idle qualification not restarted");
   pw_return_a: assert property (
      $fell(dischargeOn) && dischPw_q |-> highLimitOn)
      else $error("Supply wake return without high limit");
   load_set_a: assert property (
      loadDet && !ppm_q && qualIf.done |=> ppm_q)
      else $error("Heavy load did not assert status");
   load_clear_a: assert property (
      loadDet && ppm_q && qualIf.done |=> !ppm_q)
      else $error("Light load did not release status");
   cdp_standard_port_variant_two_a: assert property (
      mode_q == MODE_CDP && target == MODE_STANDARD_PORT_VARIANT_TWO |=> mode_q == MODE_STANDARD_PORT_VARIANT_TWO)
      else $error("Charging port to variant two not direct");
   mode_disch_a: assert property (
      mode_q == MODE_STANDARD_PORT_VARIANT_ONE && target == MODE_CDP |=> dischargeOn)
      else $error("Move to 111 state without discharge");
   standard_port_variant_one_low_a: assert property (
      mode_q == MODE_STANDARD_PORT_VARIANT_ONE && !limitSelectPin |-> !highLimitOn)
      else $error("Standard port with limit select low on high limit");

   hold_cov: cover property (hold ##1 wakeRun_q);
   pw_cov: cover property (pwActive && pwLow_q ##1 !pwLow_q);
   ppm_cov: cover property (!ppm_q ##1 ppm_q);
   wake_cov: cover property (hold && wakeIf.done);
   disch_cov: cover property (dischargeOn ##1 !dischargeOn);
endmodule
`default_nettype wire

// ===== cpw_host_model.sv
// Behavioural system power controller that drives the control pins
`timescale 1ns/1ps
`default_nettype none
module cpw_host_model #(
   parameter int RESTORE_CYC = 60
)(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [3:0] cmdReq,
   input  wire logic [3:0] restorePins,
   input  wire logic       restoreOn,
   input  wire logic       ppmOn,
   input  wire logic       statusOe_n,
   input  wire logic       dMinusHigh,
   output logic            modePinA,
   output logic            modePinB,
   output logic            modePinC,
   output logic            limitSelectPin
);
   logic [3:0] pins_q;
   logic       dPrev_q;
   logic       held_q;
   logic       ppm_q;
   int         cnt_q;

   assign {modePinA, modePinB, modePinC, limitSelectPin} = pins_q;

   // ===================================================================
   // Pin driving, wake restore and port power allocation
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pins_q  <= 4'h0;
         dPrev_q <= 1'h0;
         held_q  <= 1'h0;
         ppm_q   <= 1'h0;
         cnt_q   <= 0;
      end else begin
         dPrev_q <= dMinusHigh;
         if (!ppmOn) ppm_q <= 1'h0;
         else if (!statusOe_n) ppm_q <= 1'h1;
         if (cnt_q == 1) begin
            pins_q <= restorePins;
            held_q <= 1'h1;
         end
         if (cnt_q > 0) cnt_q <= cnt_q - 1;
         else if (restoreOn && !held_q && dPrev_q && !dMinusHigh) begin
            cnt_q <= RESTORE_CYC;
         end
         if (!restoreOn) held_q <= 1'h0;
         if (cnt_q == 0 && !held_q) begin
            pins_q <= ppm_q ? {cmdReq[3:1], 1'h0} : cmdReq;
         end
      end
   end
endmodule
`default_nettype wire

// ===== cpw_charge_port_ctrl_tb.sv
// Self-checking testbench of the charge port control logic
`timescale 1ns/1ps
`default_nettype none
module cpw_charge_port_ctrl_tb
   import cpw_pkg::*;
   ;
   localparam int         TICK = 2;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   localparam logic [31:0] MMSK = 32'h0000_0700;
   localparam logic [6:0] O_ER = 7'h40;
   localparam logic [6:0] O_ST = 7'h20;
   localparam logic [6:0] O_DS = 7'h10;
   localparam logic [6:0] O_DC = 7'h08;
   localparam logic [6:0] O_PW = 7'h04;
   localparam logic [6:0] O_HL = 7'h02;
   localparam logic [6:0] O_SW = 7'h01;
   typedef struct packed {
      logic [31:0] e;
      logic [31:0] m;
      logic [6:0]  oe;
      logic [6:0]  om;
   } cpw_note_t;

   cpw_note_t   notes[$];
   cpw_note_t   cur;
   logic        mclk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
   logic        pwrite = 1'h0, dMinusHigh = 1'h0, loadAboveOn = 1'h0;
   logic        loadBelowOff = 1'h0, loadBelow45 = 1'h0, limit55Hit = 1'h0;
   logic        primaryDetect = 1'h0, restoreOn = 1'h0, ppmOn = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0]  cmdReq = 4'h0, restorePins = 4'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, statusOe_n, dataSwitchOn, dischargeOn;
   logic        powerSwitchOn, highLimitOn, supplyWakeLimitOn;
   logic        modePinA, modePinB, modePinC, limitSelectPin;
   logic [6:0]  outs;
   int          numErrors = 0, samplesChecked = 0, cycles = 0;

   assign outs = {pslverr, statusOe_n, dataSwitchOn, dischargeOn,
                  powerSwitchOn, highLimitOn, supplyWakeLimitOn};

   always #2.5 mclk = ~mclk;

   cpw_charge_port_ctrl #(.TICK_CYC(TICK)) cpw_charge_port_ctrl_inst (
      .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .modePinA, .modePinB, .modePinC, .limitSelectPin,
      .dMinusHigh, .loadAboveOn, .loadBelowOff, .loadBelow45, .limit55Hit,
      .primaryDetect, .statusO(), .statusOe_n, .dataSwitchOn, .dischargeOn,
      .powerSwitchOn, .highLimitOn, .supplyWakeLimitOn);

   cpw_host_model #(.RESTORE_CYC(60)) cpw_host_model_inst (
      .mclk, .rst_n, .cmdReq, .restorePins, .restoreOn, .ppmOn,
      .statusOe_n, .dMinusHigh, .modePinA, .modePinB, .modePinC,
      .limitSelectPin);

   // ===================================================================
   // Bus and check tasks
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge mclk);
   endtask

   task automatic chk(input logic [7:0] a, input logic [31:0] e, m,
                      input logic [6:0] oe, om);
      notes.push_back('{e, m, oe, om});
      apb(1'h0, a, 32'h0000_0000);
   endtask

   task automatic chkMode(input cpw_mode_t md, input logic [6:0] oe, om);
      chk(ADDR_STATE, 32'(md) << ST_MODE_LSB, MMSK, oe, om);
   endtask

   task automatic wt(input int t);
      repeat (t * TICK) @(posedge mclk);
   endtask

   task automatic pins(input logic [2:0] c, input logic l);
      cmdReq <= {c, l};
      @(posedge mclk);
   endtask

   task automatic finishTest();
      $display("checks %0d errors %0d", samplesChecked, numErrors);
      if (numErrors == 0 && samplesChecked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ===================================================================
   // Result watcher and timeout
   always @(posedge mclk) begin
      if (psel && penable && pready === 1'h1 && !pwrite
          && notes.size() > 0) begin
         cur = notes.pop_front();
         samplesChecked++;
         if ((((prdata ^ cur.e) & cur.m) !== 32'h0000_0000) ||
             (((outs ^ cur.oe) & cur.om) !== 7'h00)) begin
            numErrors++;
            $display("[ERR] reg %0h exp %h/%h seen %h/%h", paddr, cur.e,
                     cur.oe, prdata, outs);
         end
      end
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 70000) begin
         numErrors++;
         $display("[ERR] run exp done seen timeout");
         finishTest();
      end
   end

   // ===================================================================
   // Main sequence
   initial begin
      logic [31:0] r;
      logic [2:0]  sc;
      cpw_mode_t   sm;
      int          i;
      repeat (10) @(posedge mclk);
      rst_n <= 1'h1;
      @(posedge mclk);
      void'($urandom(83254));
      r = $urandom();
      chk(ADDR_CTRL, 32'(CTRL_RESET), ALL, O_ST, 7'h7F);
      chkMode(MODE_OFF, O_ST, 7'h7F);
      apb(1'h1, ADDR_CTRL, r);
      chk(ADDR_CTRL, {30'h0000_0000, r[1:0]}, ALL, 7'h00, 7'h00);
      chk(8'hFC, 32'h0000_0000, ALL, O_ER, O_ER);
      apb(1'h1, ADDR_CTRL, 32'(CTRL_RESET));
      $display("test registers done");

      pins(3'h4, 1'h1);
      wt(14);
      chkMode(MODE_FORCED, O_PW | O_HL, O_PW | O_HL | O_DS | O_DC);

      pins(CMD_CDP, 1'h0);
      wt(14);
      chkMode(MODE_STANDARD_PORT_VARIANT_TWO, O_DS | O_PW, O_DS | O_PW | O_HL | O_DC);
      pins(CMD_CDP, 1'h1);
      wt(2);
      chkMode(MODE_CDP, O_DS | O_HL, O_DS | O_HL | O_DC);
      pins(CMD_SDP1A, 1'h1);
      wt(14);
      pins(CMD_CDP, 1'h1);
      wt(1);
      chkMode(MODE_DISCH, O_DC, O_DC | O_DS);
      wt(14);
      chkMode(MODE_CDP, O_DS, O_DS | O_DC);
      $display("test data modes done");

      for (i = 0; i < 4; i++) begin
         sc = i[1] ? CMD_SDP1B : CMD_CDP;
         sm = i[1] ? MODE_STANDARD_PORT_VARIANT_ONE : MODE_CDP;
         restorePins <= {sc, 1'h1};
         dMinusHigh <= 1'h0;
         pins(CMD_OFF, 1'h0);
         wt(14);
         pins(sc, 1'h1);
         wt(14);
         dMinusHigh <= 1'h1;
         wt(2);
         chk(ADDR_STATE, 32'h0000_0008, 32'h0000_0008, 7'h00, 7'h00);
         pins(CMD_AUTO, 1'h1);
         wt(14);
         chk(ADDR_STATE, (32'(sm) << ST_MODE_LSB) | 32'h0000_0010,
             MMSK | 32'h0000_0010, O_DS, O_DS | O_DC);
         restoreOn <= i[0];
         dMinusHigh <= 1'h0;
         repeat (2) @(posedge mclk);
         dMinusHigh <= 1'h1;
         wt(58);
         chkMode(sm, O_DS, O_DS);
         wt(12);
         if (i[0])
            chkMode(sm, O_DS, O_DS);
         else
            chkMode(MODE_AUTO, 7'h00, O_DS);
         restoreOn <= 1'h0;
      end
      for (i = 0; i < 2; i++) begin
         dMinusHigh <= 1'h0;
         pins(CMD_OFF, 1'h0);
         wt(14);
         pins(i[0] ? CMD_CDP : CMD_SDP1A, 1'h1);
         wt(14);
         dMinusHigh <= ~i[0];
         wt(2);
         pins(CMD_AUTO, 1'h1);
         wt(30);
         chk(ADDR_STATE, 32'(MODE_AUTO) << ST_MODE_LSB,
             MMSK | 32'h0000_0008, 7'h00, O_DS);
      end
      dMinusHigh <= 1'h0;
      $display("test wake hold done");

      for (i = 0; i < 2; i++) begin
         pins(CMD_OFF, 1'h0);
         wt(14);
         pins(i[0] ? CMD_AUTO : CMD_CDP, 1'h1);
         wt(14);
         loadAboveOn <= 1'h1;
         wt(196);
         chk(ADDR_STATE, 32'h0000_0000, 32'h0000_0001, O_ST, O_ST);
         wt(8);
         chk(ADDR_STATE, 32'h0000_0001, 32'h0000_0001, 7'h00, O_ST);
         loadAboveOn <= 1'h0;
         loadBelowOff <= 1'h1;
         wt(2994);
         chk(ADDR_STATE, 32'h0000_0001, 32'h0000_0001, 7'h00, O_ST);
         wt(8);
         chk(ADDR_STATE, 32'h0000_0000, 32'h0000_0001, O_ST, O_ST);
         loadBelowOff <= 1'h0;
      end
      pins(CMD_OFF, 1'h0);
      wt(14);
      pins(CMD_CDP, 1'h1);
      wt(14);
      primaryDetect <= 1'h1;
      @(posedge mclk);
      primaryDetect <= 1'h0;
      chk(ADDR_STATE, 32'h0000_0001, 32'h0000_0001, 7'h00, O_ST);
      ppmOn <= 1'h1;
      wt(4);
      chkMode(MODE_STANDARD_PORT_VARIANT_TWO, O_DS, O_DS | O_HL | O_DC);
      ppmOn <= 1'h0;
      wt(4);
      chkMode(MODE_CDP, O_DS | O_HL, O_DS | O_HL | O_DC);
      $display("test load detect done");

      pins(CMD_OFF, 1'h0);
      wt(14);
      pins(CMD_PWAUTO, 1'h1);
      wt(14);
      chkMode(MODE_AUTO, O_PW | O_HL, O_ST | O_PW | O_HL | O_SW);
      loadBelow45 <= 1'h1;
      wt(14990);
      chk(ADDR_STATE, 32'h0000_0000, 32'h0000_0002, 7'h00, O_ST | O_SW);
      wt(14);
      chk(ADDR_STATE, 32'h0000_0002, 32'h0000_0003, O_ST | O_SW,
          O_ST | O_SW);
      loadBelow45 <= 1'h0;
      limit55Hit <= 1'h1;
      @(posedge mclk);
      limit55Hit <= 1'h0;
      chkMode(MODE_DISCH, O_DC, O_ST | O_DC | O_DS);
      wt(320);
      chkMode(MODE_DISCH, O_DC, O_DC | O_DS);
      wt(16);
      chkMode(MODE_AUTO, O_PW | O_HL, O_PW | O_HL | O_SW | O_DC);
      $display("test supply wake done");
      finishTest();
   end
endmodule
`default_nettype wire
